//--- verilog/receive_queue_host_readout.sv
`timescale 1ns/1ps
// Summary of operation
// - Header: status at 0, count at 2
// - Frame data keeps CRC, at most 2000 bytes
// - Big endian swaps header word bytes
// - Control one: bit10 flow, bit0 block enable
// - Separate ICMP, UDP, TCP, IP checksum enables
// - Read-only head frame status register
// - Read-only head frame 12-bit byte count
// - Queue control bit3 starts data port access
// - Queue control bit4 enables automatic release
// - Bit5 frame threshold enable, bit10 hit
// - Bit6 byte threshold enable, bit11 hit
// - Bit7 timer threshold enable, bit12 hit
// - Bit9 inserts two bytes before IP header
// - Pointer bit14 auto-advances on data access
// - Microsecond residence timer sets status, interrupt
// - Byte count over threshold raises interrupt
// - Frame count over threshold raises interrupt
// - Frame count snapshot at interrupt, read-only
// - Enable bit13 gates receive interrupt output
// - Interrupt status cleared by writing ones
// - First data port read is dummy
module receive_queue_host_readout
#(
  parameter int DEPTH = 6144
)
(
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire rxq_pkg::reg_req_t  regReq,
  output rxq_pkg::word_t          rdData,
  input  wire rxq_pkg::mac_beat_t macIn,
  output logic                    macReady,
  output logic                    pauseRequest,
  output rxq_pkg::csum_t          checksumEnable,
  output logic                    rxIrq
);
  import rxq_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] MAX_FOOT = (AW+1)'((HDR_BYTES + FRAME_MAX_BYTES + DWORD_BYTES - 1) / DWORD_BYTES * HDR_WORDS);

  // Address add with wrap at the queue depth
  function automatic logic [AW-1:0] wrapAdd(input logic [AW-1:0] b, input logic [AW-1:0] o);
    logic [AW:0] s;
    s = {1'b0, b} + {1'b0, o};
    if (s >= (AW+1)'(DEPTH))
      s = s - (AW+1)'(DEPTH);
    return s[AW-1:0];
  endfunction

  // Words a frame takes, rounded to a double word
  function automatic logic [AW:0] footOf(input logic [LEN_W-1:0] len);
    logic [LEN_W:0] t;
    t = {1'b0, len} + (LEN_W+1)'(HDR_BYTES + DWORD_BYTES - 1);
    return (AW+1)'({t[LEN_W:DWORD_SHIFT], 1'b0});
  endfunction

  // Byte pointer at which the host has read a whole padded frame
  function automatic logic [PTR_W:0] readEndOf(input logic [LEN_W-1:0] len, input logic off);
    logic [LEN_W:0] t;
    t = {1'b0, len} + (LEN_W+1)'(HDR_BYTES + DWORD_BYTES - 1) + (off ? (LEN_W+1)'(IP_OFS_BYTES) : '0);
    t[DWORD_SHIFT-1:0] = '0;
    return t[PTR_W:0];
  endfunction

  // Word index inside a frame for a host byte pointer
  function automatic logic [AW-1:0] wordOf(input logic [PTR_W-1:0] p, input logic off);
    logic [PTR_W-1:0] q;
    q = (off && p >= PTR_W'(HDR_BYTES + IP_OFS_BYTES)) ? p - PTR_W'(IP_OFS_BYTES) : p;
    return AW'(q >> WORD_SHIFT);
  endfunction

  // Byte swap for big endian presentation
  function automatic word_t swap16(input word_t w);
    return {w[7:0], w[15:8]};
  endfunction

  // Register file state
  word_t            rxCtl1Reg, rxCtl1Next;    // Receive control one
  word_t            rxCtl2Reg, rxCtl2Next;    // Receive control two
  word_t            qCtlReg, qCtlNext;        // Queue control and hit flags
  word_t            ptrReg, ptrNext;          // Data pointer and auto bit
  word_t            tmrThrReg, tmrThrNext;    // Residence threshold in us
  word_t            byteThrReg, byteThrNext;  // Byte count threshold
  word_t            ierReg, ierNext;          // Interrupt enables
  logic             isrReg, isrNext;          // Receive interrupt status
  logic [7:0]       fcThrReg, fcThrNext;      // Frame count threshold
  logic [7:0]       fcSnapReg, fcSnapNext;    // Frame count at interrupt
  word_t            cfgReg, cfgNext;          // Endian select
  logic             dummyReg, dummyNext;      // Next data read is dummy
  word_t            rdDataReg, rdDataNext;    // Read answer
  logic             irqReg, irqNext;          // Gated interrupt
  logic             pauseReg, pauseNext;      // Flow control request
  // Writer state
  wr_phase_t        phaseReg, phaseNext;      // Data, then header words
  logic             inFrameReg, inFrameNext;  // Frame under way
  logic [AW-1:0]    wrOffReg, wrOffNext;      // Word offset in frame
  logic [LEN_W-1:0] lenReg, lenNext;          // Stored byte count
  logic [7:0]       lowByteReg, lowByteNext;  // Held even byte
  word_t            statReg, statNext;        // Frame status
  logic             readyReg, readyNext;      // Ready toward receive path
  // Queue state
  logic [AW-1:0]    headReg, headNext;        // Oldest frame base
  logic [AW-1:0]    tailReg, tailNext;        // Next frame base
  logic [AW:0]      usedReg, usedNext;        // Words in use
  logic [FC_W-1:0]  frameCntReg, frameCntNext;
  word_t            byteCntReg, byteCntNext;
  logic [6:0]       preReg, preNext;          // Microsecond prescaler
  word_t            ageReg, ageNext;          // Head residence in us
  hdr_state_t       hdrReg, hdrNext;          // Header fetch state
  word_t            headStatReg, headStatNext;
  // Memory side
  logic             memWe;
  logic [AW-1:0]    memWaddr, memRaddrA, memRaddrB;
  word_t            memWdata, memQa, memQb;
  // Shared decode
  logic             hdrValid, relHead, commit, roomOk;  // Head frame released this cycle
  logic             dataRead, isrClr, fcHit, bcHit, tmHit;
  logic [LEN_W-1:0] headLen;
  logic [AW:0]      commitFoot, releaseFoot;
  logic [PTR_W-1:0] ptrField, ptrAdv;
  word_t            portWord;

  rxq_word_mem #(.DEPTH(DEPTH), .AW(AW), .DW(16)) uMem
  (
    .clk    (sys_clk),
    .we     (memWe),
    .waddr  (memWaddr),
    .wdata  (memWdata),
    .raddrA (memRaddrA),
    .rdataA (memQa),
    .raddrB (memRaddrB),
    .rdataB (memQb)
  );

  // Head header as held by the fetch logic
  assign hdrValid    = (hdrReg == HDR_VALID);
  assign headLen     = hdrValid ? memQb[LEN_W-1:0] : '0;
  assign commit      = (phaseReg == WR_LEN);
  assign commitFoot  = footOf(lenReg);
  assign releaseFoot = footOf(headLen);
  assign ptrField    = ptrReg[PTR_W-1:0];
  assign ptrAdv      = ptrField + PTR_W'(WORD_BYTES);
  assign dataRead    = regReq.rd && regReq.addr == DATA_PORT_OFS;
  assign isrClr      = regReq.wr && regReq.addr == INT_STATUS_OFS && regReq.data[INT_RX_BIT];
  assign fcHit       = qCtlReg[QC_FC_EN_BIT] && frameCntReg > FC_W'(fcThrReg);
  assign bcHit       = qCtlReg[QC_BC_EN_BIT] && byteCntReg > byteThrReg;
  assign tmHit       = qCtlReg[QC_TM_EN_BIT] && ageReg > tmrThrReg;

  // Word shown at the data port: header bytes swapped, offset gap as zero
  always_comb
  begin
    portWord = memQa;
    if (ptrField < PTR_W'(HDR_BYTES) && cfgReg[CFG_BIG_END_BIT])
      portWord = swap16(memQa);
    else if (qCtlReg[QC_IP_OFS_BIT] && ptrField >= PTR_W'(HDR_BYTES)
             && ptrField < PTR_W'(HDR_BYTES + IP_OFS_BYTES))
      portWord = '0;
  end

  // Register writes, reads, data port and interrupt
  always_comb
  begin
    rxCtl1Next  = rxCtl1Reg;
    rxCtl2Next  = rxCtl2Reg;
    qCtlNext    = qCtlReg;
    ptrNext     = ptrReg;
    tmrThrNext  = tmrThrReg;
    byteThrNext = byteThrReg;
    ierNext     = ierReg;
    fcThrNext   = fcThrReg;
    cfgNext     = cfgReg;
    dummyNext   = dummyReg;
    rdDataNext  = '0;
    relHead     = 1'b0;
    if (regReq.wr)
    begin
      case (regReq.addr)
        RX_CTL_ONE_OFS: rxCtl1Next = regReq.data;
        RX_CTL_TWO_OFS: rxCtl2Next = regReq.data;
        QUEUE_CTL_OFS:
        begin
          qCtlNext = (qCtlReg & ~QCTL_WMASK) | (regReq.data & QCTL_WMASK);
          // Starting a data port sequence arms the dummy read
          if (regReq.data[QC_DMA_BIT] && !qCtlReg[QC_DMA_BIT])
            dummyNext = 1'b1;
          relHead = hdrValid && regReq.data[QC_RELEASE_BIT];
        end
        DATA_PTR_OFS:   ptrNext = regReq.data & PTR_WMASK;
        TIMER_THR_OFS:  tmrThrNext = regReq.data;
        BYTE_THR_OFS:   byteThrNext = regReq.data;
        INT_ENABLE_OFS: ierNext = regReq.data;
        FRAME_THR_OFS:  fcThrNext = regReq.data[7:0];
        QUEUE_CFG_OFS:  cfgNext = regReq.data;
        default:        ;
      endcase
    end
    if (regReq.rd)
    begin
      case (regReq.addr)
        RX_CTL_ONE_OFS: rdDataNext = rxCtl1Reg;
        RX_CTL_TWO_OFS: rdDataNext = rxCtl2Reg;
        HDR_STATUS_OFS: rdDataNext = hdrValid ? headStatReg : '0;
        HDR_LENGTH_OFS: rdDataNext = 16'(headLen);
        QUEUE_CTL_OFS:  rdDataNext = qCtlReg;
        DATA_PTR_OFS:   rdDataNext = ptrReg;
        TIMER_THR_OFS:  rdDataNext = tmrThrReg;
        BYTE_THR_OFS:   rdDataNext = byteThrReg;
        INT_ENABLE_OFS: rdDataNext = ierReg;
        INT_STATUS_OFS: rdDataNext = 16'(isrReg) << INT_RX_BIT;
        FRAME_THR_OFS:  rdDataNext = {fcSnapReg, fcThrReg};
        QUEUE_CFG_OFS:  rdDataNext = cfgReg;
        DATA_PORT_OFS:
        begin
          if (dummyReg)
          begin
            rdDataNext = DUMMY_WORD;
            dummyNext  = 1'b0;
          end
          else
          begin
            rdDataNext = portWord;
            if (ptrReg[PTR_AUTO_BIT])
              ptrNext[PTR_W-1:0] = ptrAdv;
            // Padded frame fully read: give its space back
            if (qCtlReg[QC_AUTO_DEQ_BIT] && hdrValid && ptrReg[PTR_AUTO_BIT]
                && {1'b0, ptrAdv} >= readEndOf(headLen, qCtlReg[QC_IP_OFS_BIT]))
              relHead = 1'b1;
          end
        end
        default:        rdDataNext = '0;
      endcase
    end
    if (relHead)
      ptrNext[PTR_W-1:0] = '0;
    // Threshold hits are sticky until cleared, a new hit wins over the clear
    qCtlNext[QC_FC_HIT_BIT] = (qCtlReg[QC_FC_HIT_BIT] && !isrClr) || fcHit;
    qCtlNext[QC_BC_HIT_BIT] = (qCtlReg[QC_BC_HIT_BIT] && !isrClr) || bcHit;
    qCtlNext[QC_TM_HIT_BIT] = (qCtlReg[QC_TM_HIT_BIT] && !isrClr) || tmHit;
    isrNext    = (isrReg && !isrClr) || fcHit || bcHit || tmHit;
    fcSnapNext = (isrNext && !isrReg) ? frameCntReg[7:0] : fcSnapReg;
    irqNext    = isrNext && ierNext[INT_RX_BIT];
    pauseNext  = rxCtl1Reg[RXC1_FLOW_BIT] && !roomOk;
  end

  // Frame writer: data bytes paired into words, then status and count
  always_comb
  begin
    phaseNext   = phaseReg;
    inFrameNext = inFrameReg;
    wrOffNext   = wrOffReg;
    lenNext     = lenReg;
    lowByteNext = lowByteReg;
    statNext    = statReg;
    memWe       = 1'b0;
    memWaddr    = tailReg;
    memWdata    = '0;
    case (phaseReg)
      WR_DATA:
      begin
        if (macIn.valid && readyReg)
        begin
          if (!inFrameReg)
          begin
            wrOffNext = AW'(HDR_WORDS);
            lenNext   = '0;
          end
          // Bytes past the size limit are dropped
          if (lenNext < LEN_W'(FRAME_MAX_BYTES))
          begin
            lowByteNext = macIn.data;
            if (lenNext[0] || macIn.last)
            begin
              memWe     = 1'b1;
              memWaddr  = wrapAdd(tailReg, wrOffNext);
              memWdata  = lenNext[0] ? {macIn.data, lowByteReg} : {8'h00, macIn.data};
              wrOffNext = wrOffNext + AW'(1);
            end
            lenNext = lenNext + LEN_W'(1);
          end
          inFrameNext = !macIn.last;
          if (macIn.last)
          begin
            phaseNext = WR_STAT;
            statNext  = macIn.status;
          end
        end
      end
      WR_STAT:
      begin
        memWe     = 1'b1;
        memWdata  = statReg;
        phaseNext = WR_LEN;
      end
      WR_LEN:
      begin
        memWe     = 1'b1;
        memWaddr  = wrapAdd(tailReg, AW'(1));
        memWdata  = 16'(lenReg);
        phaseNext = WR_DATA;
      end
      default:
        phaseNext = WR_DATA;
    endcase
    readyNext = (phaseNext == WR_DATA) && (inFrameNext || (rxCtl1Reg[RXC1_BLOCK_BIT] && roomOk));
  end

  // Queue bookkeeping, residence timer and header fetch
  always_comb
  begin
    tailNext     = commit ? wrapAdd(tailReg, commitFoot[AW-1:0]) : tailReg;
    headNext     = relHead ? wrapAdd(headReg, releaseFoot[AW-1:0]) : headReg;
    usedNext     = usedReg + (commit ? commitFoot : '0) - (relHead ? releaseFoot : '0);
    frameCntNext = frameCntReg + FC_W'(commit) - FC_W'(relHead);
    byteCntNext  = byteCntReg + (commit ? 16'(lenReg) : '0) - (relHead ? 16'(headLen) : '0);
    roomOk       = usedNext + MAX_FOOT <= (AW+1)'(DEPTH);
    preNext      = preReg;
    ageNext      = ageReg;
    // Count microseconds while a frame waits at the head
    if (frameCntReg == '0 || relHead)
    begin
      preNext = '0;
      ageNext = '0;
    end
    else if (preReg == 7'(TICK_CYCLES - 1))
    begin
      preNext = '0;
      if (ageReg != 16'hffff)
        ageNext = ageReg + 16'h0001;
    end
    else
      preNext = preReg + 7'h01;
    hdrNext      = hdrReg;
    headStatNext = headStatReg;
    memRaddrB    = headReg;
    case (hdrReg)
      HDR_IDLE:
        if (frameCntReg != '0)
          hdrNext = HDR_STAT;
      HDR_STAT:
        hdrNext = HDR_LEN;
      HDR_LEN:
      begin
        headStatNext = memQb;
        memRaddrB    = wrapAdd(headReg, AW'(1));
        hdrNext      = HDR_VALID;
      end
      HDR_VALID:
      begin
        memRaddrB = wrapAdd(headReg, AW'(1));
        if (relHead)
          hdrNext = HDR_IDLE;
      end
      default:
        hdrNext = HDR_IDLE;
    endcase
    // Data port prefetch follows the pointer of the next cycle
    memRaddrA = wrapAdd(headNext, wordOf(ptrNext[PTR_W-1:0], qCtlNext[QC_IP_OFS_BIT]));
  end

  // All state registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rxCtl1Reg <= '0;  rxCtl2Reg <= '0;  qCtlReg <= '0;  ptrReg <= '0;
      tmrThrReg <= '0;  byteThrReg <= '0; ierReg <= '0;   isrReg <= 1'b0;
      fcThrReg <= '0;   fcSnapReg <= '0;  cfgReg <= '0;   dummyReg <= 1'b0;
      rdDataReg <= '0;  irqReg <= 1'b0;   pauseReg <= 1'b0;
      phaseReg <= WR_DATA; inFrameReg <= 1'b0; wrOffReg <= '0; lenReg <= '0;
      lowByteReg <= '0; statReg <= '0;    readyReg <= 1'b0;
      headReg <= '0;    tailReg <= '0;    usedReg <= '0;  frameCntReg <= '0;
      byteCntReg <= '0; preReg <= '0;     ageReg <= '0;
      hdrReg <= HDR_IDLE; headStatReg <= '0;
    end
    else
    begin
      rxCtl1Reg <= rxCtl1Next; rxCtl2Reg <= rxCtl2Next; qCtlReg <= qCtlNext; ptrReg <= ptrNext;
      tmrThrReg <= tmrThrNext; byteThrReg <= byteThrNext; ierReg <= ierNext; isrReg <= isrNext;
      fcThrReg <= fcThrNext;   fcSnapReg <= fcSnapNext; cfgReg <= cfgNext; dummyReg <= dummyNext;
      rdDataReg <= rdDataNext; irqReg <= irqNext; pauseReg <= pauseNext;
      phaseReg <= phaseNext;   inFrameReg <= inFrameNext; wrOffReg <= wrOffNext; lenReg <= lenNext;
      lowByteReg <= lowByteNext; statReg <= statNext; readyReg <= readyNext;
      headReg <= headNext;     tailReg <= tailNext; usedReg <= usedNext; frameCntReg <= frameCntNext;
      byteCntReg <= byteCntNext; preReg <= preNext; ageReg <= ageNext;
      hdrReg <= hdrNext;       headStatReg <= headStatNext;
    end
  end

  assign rdData         = rdDataReg;
  assign macReady       = readyReg;
  assign pauseRequest   = pauseReg;
  assign checksumEnable = rxCtl2Reg[CSUM_W-1:0];
  assign rxIrq          = irqReg;

  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
    rxIrq == (isrReg && ierReg[INT_RX_BIT])) else $error("interrupt output not gated by enable");
  chk_frame_thr: assert property (@(posedge sys_clk) disable iff (srst)
    fcHit |=> isrReg && qCtlReg[QC_FC_HIT_BIT]) else $error("frame threshold hit not flagged");
  chk_byte_thr: assert property (@(posedge sys_clk) disable iff (srst)
    bcHit |=> isrReg && qCtlReg[QC_BC_HIT_BIT]) else $error("byte threshold hit not flagged");
  chk_timer_thr: assert property (@(posedge sys_clk) disable iff (srst)
    tmHit |=> isrReg && qCtlReg[QC_TM_HIT_BIT]) else $error("timer threshold hit not flagged");
  chk_dummy_read: assert property (@(posedge sys_clk) disable iff (srst)
    dataRead && dummyReg |=> rdData == DUMMY_WORD && $stable(ptrReg) && !dummyReg)
    else $error("first data read not dummy");
  chk_auto_step: assert property (@(posedge sys_clk) disable iff (srst)
    dataRead && !dummyReg && ptrReg[PTR_AUTO_BIT] && !relHead
    |=> ptrReg[PTR_W-1:0] == $past(ptrReg[PTR_W-1:0]) + PTR_W'(WORD_BYTES))
    else $error("pointer did not advance");
  chk_len_limit: assert property (@(posedge sys_clk) disable iff (srst)
    lenReg <= LEN_W'(FRAME_MAX_BYTES)) else $error("stored frame longer than limit");
  chk_w1c_clear: assert property (@(posedge sys_clk) disable iff (srst)
    isrClr && !fcHit && !bcHit && !tmHit |=> !isrReg) else $error("status not cleared by one");
  chk_release_next: assert property (@(posedge sys_clk) disable iff (srst)
    relHead |=> hdrReg == HDR_IDLE ##0 (frameCntReg == '0) or ##[1:2] hdrReg == HDR_LEN)
    else $error("next header not fetched after release");

endmodule

//--- verilog/rxq_pkg.sv
package rxq_pkg;

  // Host register offsets
  localparam logic [7:0] RX_CTL_ONE_OFS  = 8'h74;
  localparam logic [7:0] RX_CTL_TWO_OFS  = 8'h76;
  localparam logic [7:0] HDR_STATUS_OFS  = 8'h7c;
  localparam logic [7:0] HDR_LENGTH_OFS  = 8'h7e;
  localparam logic [7:0] QUEUE_CTL_OFS   = 8'h82;
  localparam logic [7:0] DATA_PTR_OFS    = 8'h86;
  localparam logic [7:0] TIMER_THR_OFS   = 8'h8c;
  localparam logic [7:0] BYTE_THR_OFS    = 8'h8e;
  localparam logic [7:0] INT_ENABLE_OFS  = 8'h90;
  localparam logic [7:0] INT_STATUS_OFS  = 8'h92;
  localparam logic [7:0] FRAME_THR_OFS   = 8'h9c;
  localparam logic [7:0] DATA_PORT_OFS   = 8'hd0;
  localparam logic [7:0] QUEUE_CFG_OFS   = 8'hd2;

  // Field positions
  localparam int RXC1_BLOCK_BIT  = 0;
  localparam int RXC1_FLOW_BIT   = 10;
  localparam int QC_RELEASE_BIT  = 0;
  localparam int QC_DMA_BIT      = 3;
  localparam int QC_AUTO_DEQ_BIT = 4;
  localparam int QC_FC_EN_BIT    = 5;
  localparam int QC_BC_EN_BIT    = 6;
  localparam int QC_TM_EN_BIT    = 7;
  localparam int QC_IP_OFS_BIT   = 9;
  localparam int QC_FC_HIT_BIT   = 10;
  localparam int QC_BC_HIT_BIT   = 11;
  localparam int QC_TM_HIT_BIT   = 12;
  localparam int PTR_AUTO_BIT    = 14;
  localparam int INT_RX_BIT      = 13;
  localparam int CFG_BIG_END_BIT = 0;
  localparam int PTR_W           = 11;
  localparam int LEN_W           = 12;
  localparam int FC_W            = 10;
  localparam int CSUM_W          = 4;

  // Writable masks and fixed words
  localparam logic [15:0] QCTL_WMASK = 16'h02f8;
  localparam logic [15:0] PTR_WMASK  = 16'h47ff;
  localparam logic [15:0] DUMMY_WORD = 16'h0000;

  // Frame layout in bytes and words
  localparam int FRAME_MAX_BYTES = 2000;
  localparam int HDR_BYTES       = 4;
  localparam int HDR_WORDS       = 2;
  localparam int IP_OFS_BYTES    = 2;
  localparam int DWORD_BYTES     = 4;
  localparam int DWORD_SHIFT     = 2;
  localparam int WORD_BYTES      = 2;
  localparam int WORD_SHIFT      = 1;

  // Residence timer tick
  localparam int TICK_NS       = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef logic [15:0]       word_t;
  typedef logic [CSUM_W-1:0] csum_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    word_t      data;
  } reg_req_t;

  // One received byte from the receive path
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
    word_t      status;
  } mac_beat_t;

  typedef enum logic [1:0] {WR_DATA = 2'b00, WR_STAT = 2'b01, WR_LEN = 2'b11} wr_phase_t;
  typedef enum logic [1:0] {HDR_IDLE = 2'b00, HDR_STAT = 2'b01, HDR_LEN = 2'b11, HDR_VALID = 2'b10} hdr_state_t;

endpackage

//--- verilog/rxq_word_mem.sv
`timescale 1ns/1ps
module rxq_word_mem
#(
  parameter int DEPTH = 6144,
  parameter int AW    = 13,
  parameter int DW    = 16
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddrA,
  output logic      [DW-1:0] rdataA,
  input  wire logic [AW-1:0] raddrB,
  output logic      [DW-1:0] rdataB
);

  logic [DW-1:0] store [DEPTH];  // Frame words

  // One write port, two registered read ports
  always_ff @(posedge clk)
  begin
    if (we)
      store[waddr] <= wdata;
    rdataA <= store[raddrA];
    rdataB <= store[raddrB];
  end

endmodule

//--- tb/mac_src.sv
`timescale 1ns/1ps
// Byte source standing in for the receive path
module mac_src
  import rxq_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          macReady,
  output rxq_pkg::mac_beat_t macIn
);
  // Idle until the first frame
  initial macIn = '0;
  // Sends n bytes 8'h10+i, status rides with the last byte
  task automatic send(input int n, input word_t st);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      macIn <= '{valid: 1'b1, last: (i == n - 1), data: 8'h10 + i[7:0], status: st};
      // Hold the byte until an edge that sees ready high
      @(negedge sys_clk);
      while (!macReady) @(negedge sys_clk);
    end
    @(posedge sys_clk);
    // Released lines show inverted stale values, never the last byte
    macIn <= '{valid: 1'b0, last: 1'b0, data: ~macIn.data, status: ~macIn.status};
  endtask
endmodule

//--- tb/receive_queue_host_readout_tb.sv
`timescale 1ns/1ps
// Register-level test of the receive queue readout
module receive_queue_host_readout_tb;
  import rxq_pkg::*;
  logic      sysClk;  // 100 MHz clock
  logic      srst;    // Synchronous reset
  reg_req_t  regReq;  // Register port request
  word_t     rdData;  // Register read answer
  mac_beat_t macIn;   // Receive byte stream
  logic      macReady;
  logic      rxIrq;
  csum_t     csumEn;    // Checksum check enables
  logic      pauseReq;  // Flow control request
  word_t     got;     // Last read value
  int        errors;
  int        comparisons;
  // Design under test, small queue depth
  receive_queue_host_readout #(.DEPTH(2048)) u_receive_queue_host_readout (.sys_clk(sysClk), .srst(srst),
    .regReq(regReq), .rdData(rdData), .macIn(macIn), .macReady(macReady), .pauseRequest(pauseReq),
    .checksumEnable(csumEn), .rxIrq(rxIrq));
  // Receive path model
  mac_src u_mac_src (.sys_clk(sysClk), .macReady(macReady), .macIn(macIn));
  // Clock
  initial
  begin
    sysClk = 1'b0;
    forever #5 sysClk = ~sysClk;
  end
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge sysClk) regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge sysClk) regReq <= '0;
  endtask
  // One-cycle read strobe, answer taken the cycle after
  task automatic rd(input logic [7:0] a);
    @(posedge sysClk) regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
    @(posedge sysClk) regReq <= '0;
    #1 got = rdData;
  endtask
  // Word comparison
  task automatic chkw(input word_t g, input word_t e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, g, e);
    end
  endtask
  // Flag comparison
  task automatic chkb(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, g, e);
    end
  endtask
  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
  // Test sequence
  initial
  begin
    errors = 0;
    comparisons = 0;
    regReq = '0;
    srst = 1'b1;
    repeat (2) @(posedge sysClk);
    srst <= 1'b0;
    rd(QUEUE_CTL_OFS);         chkw(got, 16'h0000);
    rd(8'h00);                 chkw(got, 16'h0000);
    wr(RX_CTL_ONE_OFS, 16'h0401);
    rd(RX_CTL_ONE_OFS);        chkw(got, 16'h0401);
    wr(RX_CTL_TWO_OFS, 16'h0009);
    @(posedge sysClk);
    #1 chkw({12'h000, csumEn}, 16'h0009);
    // Frame count threshold 0, interrupt enabled
    wr(FRAME_THR_OFS, 16'h0000);
    wr(QUEUE_CTL_OFS, 16'h0020);
    wr(INT_ENABLE_OFS, 16'h2000);
    u_mac_src.send(6, 16'h8001);
    repeat (10) @(posedge sysClk);
    #1 chkb(rxIrq, 1'b1);
    rd(QUEUE_CTL_OFS);         chkw(got, 16'h0420);
    rd(FRAME_THR_OFS);         chkw(got, 16'h0100);
    rd(HDR_STATUS_OFS);        chkw(got, 16'h8001);
    rd(HDR_LENGTH_OFS);        chkw(got, 16'h0006);
    chkb(pauseReq, 1'b0);
    wr(QUEUE_CTL_OFS, 16'h0000);
    wr(INT_STATUS_OFS, 16'hffff);
    @(posedge sysClk);
    #1 chkb(rxIrq, 1'b0);
    // Auto-advancing readout with automatic release
    wr(DATA_PTR_OFS, 16'h4000);
    wr(QUEUE_CTL_OFS, 16'h0018);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0000);
    rd(DATA_PORT_OFS);         chkw(got, 16'h8001);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0006);
    rd(DATA_PORT_OFS);         chkw(got, 16'h1110);
    rd(DATA_PORT_OFS);         chkw(got, 16'h1312);
    rd(DATA_PORT_OFS);         chkw(got, 16'h1514);
    rd(DATA_PORT_OFS);
    repeat (6) @(posedge sysClk);
    rd(DATA_PTR_OFS);          chkw(got, 16'h4000);
    rd(HDR_LENGTH_OFS);        chkw(got, 16'h0000);
    // Big endian header, IP offset gap, byte and timer thresholds, manual release
    wr(QUEUE_CFG_OFS, 16'h0001);
    wr(BYTE_THR_OFS, 16'h0004);
    wr(TIMER_THR_OFS, 16'h0001);
    wr(QUEUE_CTL_OFS, 16'h02c0);
    u_mac_src.send(6, 16'h8002);
    repeat (300) @(posedge sysClk);
    #1 chkb(rxIrq, 1'b1);
    rd(QUEUE_CTL_OFS);         chkw(got, 16'h1ac0);
    rd(HDR_STATUS_OFS);        chkw(got, 16'h8002);
    wr(QUEUE_CTL_OFS, 16'h02c8);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0000);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0280);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0600);
    rd(DATA_PORT_OFS);         chkw(got, 16'h0000);
    rd(DATA_PORT_OFS);         chkw(got, 16'h1110);
    wr(QUEUE_CTL_OFS, 16'h0001);
    wr(INT_STATUS_OFS, 16'hffff);
    repeat (4) @(posedge sysClk);
    #1 chkb(rxIrq, 1'b0);
    rd(QUEUE_CTL_OFS);         chkw(got, 16'h0000);
    rd(DATA_PTR_OFS);          chkw(got, 16'h4000);
    rd(HDR_LENGTH_OFS);        chkw(got, 16'h0000);
    print_verdict();
  end
endmodule
